// >>> rtl/dcsw_control_status.sv
// How it works
// RULE_01: bit meanings apply only under native profile
// RULE_02: bits 1:0 pick stored speed target
// RULE_03: bit 2 low forces DC brake stop
// RULE_04: bit 3 low coasts, output stage off
// RULE_05: bit 4 low ramps down, quick-stop time
// RULE_06: bit 5 low holds output frequency
// RULE_07: frozen drive stops only by coast/brake
// RULE_08: bit 6 low ramps stop, high starts
// RULE_09: trip reset on bit 7 rising edge
// RULE_10: bit 8 high selects jog frequency
// RULE_11: bit 9 selects ramp pair
// RULE_12: bit 10 low ignores whole word
// RULE_13: bits 11,12 drive relay and output
// RULE_14: bits 14:13 pick configuration set
// RULE_15: bit 15 reverses unless source is input
// RULE_16: per-function setting gates bus with input
// RULE_17: status ready and coasting-ready bits
// RULE_18: status bit 2 shows start possible
// RULE_19: status bit 3 shows trip
// RULE_20: status bit 6 shows trip lock
// RULE_21: status bit 7 shows warning
// RULE_22: status bit 8 low when speed differs
// RULE_23: status bit 8 high at reference
// RULE_24: status bit 9 shows bus control possible
// RULE_25: status bit 11 shows running
// RULE_26: status bit 14 shows current limit
// RULE_27: undefined status bits read zero
`timescale 1ns/1ps
module dcsw_control_status
  import dcsw_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           reset,
  input  wire logic           clk_en,
  input  wire logic [1:0]     telegram_profile,
  input  wire logic           cmd_load,
  input  wire logic [15:0]    drive_command_word,
  input  wire dcsw_gate_cfg_t gate_cfg,
  input  wire dcsw_din_t      din,
  input  wire logic           multi_set_mode,
  input  wire logic           relay_bus_assigned,
  input  wire logic           dout_bus_assigned,
  input  wire dcsw_drv_sts_t  drv,
  output logic [1:0]          speed_target_sel,
  output logic                jog_sel,
  output logic                ramp_pair_sel,
  output logic                ramp_use_quick,
  output logic                freeze_freq,
  output logic                freq_speed_up,
  output logic                freq_speed_down,
  output logic                outputs_enable,
  output logic                dc_brake,
  output logic                ramp_down,
  output logic                run_request,
  output logic                reverse_dir,
  output logic [1:0]          config_set_sel,
  output logic                relay_out,
  output logic                digital_out,
  output logic                trip_reset,
  output dcsw_state_t         stop_state,
  output logic [15:0]         drive_state_word
);

  // ************************************************************
  // accepted command word
  // ************************************************************
  logic [15:0] cmd_ff;
  logic [15:0] nxt_cmd;
  logic        profile_ok;
  logic        take;

  // other profiles carry other bit maps, so their words are dropped whole
  assign profile_ok = (telegram_profile == DCSW_NATIVE_DRIVE_PROFILE);  // RULE_01

  // only a valid word under the native profile replaces the held one
  assign take = cmd_load && profile_ok && drive_command_word[CMD_VALID];  // RULE_12

  always_comb begin
    nxt_cmd = cmd_ff;
    if (take) begin
      nxt_cmd = drive_command_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_ff <= DCSW_CMD_RST;
    end else if (clk_en) begin
      cmd_ff <= nxt_cmd;
    end
  end

  // ************************************************************
  // trip reset edge
  // ************************************************************
  logic rst_bit_ff;
  logic nxt_rst_bit;
  logic rst_edge;

  // judged against the last accepted word, so ignored words break no edge
  assign rst_edge = take && drive_command_word[CMD_RESET] && !rst_bit_ff;  // RULE_09

  always_comb begin
    nxt_rst_bit = rst_bit_ff;
    if (take) begin
      nxt_rst_bit = drive_command_word[CMD_RESET];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rst_bit_ff <= DCSW_CMD_RST[CMD_RESET];
    end else if (clk_en) begin
      rst_bit_ff <= nxt_rst_bit;
    end
  end

  // ************************************************************
  // gated functions
  // ************************************************************
  logic       coast_n;
  logic       dcbrk_n;
  logic       start;
  logic       reverse;
  logic [1:0] setsel;
  logic [1:0] target;

  // word at reset has stop bits low: safe stopped state until a valid word
  always_comb begin
    coast_n   = dcsw_gate(gate_cfg.coast, cmd_ff[CMD_COAST_N], din.coast_n) & ~din.reset_coast;  // RULE_16
    dcbrk_n   = dcsw_gate(gate_cfg.dcbrk, cmd_ff[CMD_DCBRK_N], din.dcbrk_n);                     // RULE_16
    start     = dcsw_gate(gate_cfg.start, cmd_ff[CMD_START], din.start);                         // RULE_16
    reverse   = dcsw_gate(gate_cfg.reverse, cmd_ff[CMD_REVERSE], din.reverse);                   // RULE_15
  end

  // ************************************************************
  // selector pairs
  // ************************************************************
  // the loop walks each pair from its low bit upward
  if (CMD_SET_HI != CMD_SET_LO + 1 || CMD_TGT_HI != CMD_TGT_LO + 1) begin : g_pair_chk
    $error("selector bits must be adjacent");
  end

  // both bits of one selector share one combining setting
  for (genvar b = 0; b < 2; b++) begin : g_sel
    assign setsel[b] = dcsw_gate(gate_cfg.setsel, cmd_ff[CMD_SET_LO + b], din.setsel[b]);  // RULE_16
    assign target[b] = dcsw_gate(gate_cfg.target, cmd_ff[CMD_TGT_LO + b], din.target[b]);  // RULE_16
  end

  // ************************************************************
  // stop sequencing
  // ************************************************************
  dcsw_state_t st_ff;
  dcsw_state_t nxt_st;
  logic        frozen_req;

  assign frozen_req = ~cmd_ff[CMD_FREEZE_N];

  always_comb begin
    nxt_st = st_ff;
    if (!coast_n) begin
      nxt_st = DCSW_ST_COAST;                          // RULE_04
    end else if (!dcbrk_n) begin
      nxt_st = DCSW_ST_DCBRAKE;                        // RULE_03
    end else if (frozen_req && st_ff == DCSW_ST_RUN) begin
      nxt_st = DCSW_ST_FROZEN;                         // RULE_06
    end else if (st_ff == DCSW_ST_FROZEN) begin
      // start bit and start input cannot end the hold
      if (!frozen_req) begin                           // RULE_07
        nxt_st = DCSW_ST_RUN;
      end
    end else if (!cmd_ff[CMD_QSTOP_N]) begin
      nxt_st = DCSW_ST_QSTOP;                          // RULE_05
    end else if (!start) begin
      nxt_st = DCSW_ST_RAMP_STOP;                      // RULE_08
    end else if (!drv.tripped && !drv.trip_locked && drv.ready) begin
      nxt_st = DCSW_ST_RUN;                            // RULE_04 RULE_08
    end else begin
      nxt_st = DCSW_ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= DCSW_ST_IDLE;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // state decode
  // ************************************************************
  logic go_run;
  logic go_frozen;
  logic go_qstop;
  logic go_ramp;
  logic go_brake;
  logic go_coast;

  // outputs follow the state being entered so they line up with stop_state
  always_comb begin
    go_run    = (nxt_st == DCSW_ST_RUN);
    go_frozen = (nxt_st == DCSW_ST_FROZEN);
    go_qstop  = (nxt_st == DCSW_ST_QSTOP);
    go_ramp   = (nxt_st == DCSW_ST_RAMP_STOP);
    go_brake  = (nxt_st == DCSW_ST_DCBRAKE);
    go_coast  = (nxt_st == DCSW_ST_COAST);
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  // one flop per output keeps every port a plain register
  logic [1:0] tgt_ff;
  logic [1:0] nxt_tgt;
  logic       jog_ff;
  logic       nxt_jog;
  logic       ramp2_ff;
  logic       nxt_ramp2;
  logic       quick_ff;
  logic       nxt_quick;
  logic       freeze_ff;
  logic       nxt_freeze;
  logic       up_ff;
  logic       nxt_up;
  logic       down_ff;
  logic       nxt_down;
  logic       enable_ff;
  logic       nxt_enable;
  logic       brake_ff;
  logic       nxt_brake;
  logic       rdown_ff;
  logic       nxt_rdown;
  logic       run_ff;
  logic       nxt_run;
  logic       rev_ff;
  logic       nxt_rev;
  logic [1:0] set_ff;
  logic [1:0] nxt_set;
  logic       relay_ff;
  logic       nxt_relay;
  logic       dout_ff;
  logic       nxt_dout;
  logic       trst_ff;
  logic       nxt_trst;

  always_comb begin
    nxt_tgt    = target;                                  // RULE_02
    nxt_jog    = cmd_ff[CMD_JOG];                         // RULE_10
    nxt_ramp2  = cmd_ff[CMD_RAMP2];                       // RULE_11
    nxt_quick  = go_qstop;                                // RULE_05
    nxt_freeze = go_frozen;                               // RULE_06
    nxt_up     = go_frozen & din.speed_up;                // RULE_06
    nxt_down   = go_frozen & din.speed_down;              // RULE_06
    nxt_enable = ~go_coast;                               // RULE_04
    nxt_brake  = go_brake;                                // RULE_03
    nxt_rdown  = go_ramp | go_qstop;                      // RULE_08
    // a frozen drive still runs; only its frequency is held
    nxt_run    = go_run | go_frozen;
    // input-only source: the gate already passes the input alone
    nxt_rev    = reverse;                                 // RULE_15
    // with multi-set off the last selected set stays in force
    nxt_set    = multi_set_mode ? setsel : set_ff;        // RULE_14
    nxt_relay  = relay_bus_assigned & cmd_ff[CMD_RELAY];  // RULE_13
    nxt_dout   = dout_bus_assigned & cmd_ff[CMD_DOUT];    // RULE_13
    // trip lock is not reset here; it clears only on power cycle
    nxt_trst   = rst_edge & ~drv.trip_locked;             // RULE_09 RULE_20
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tgt_ff    <= 2'h0;
      jog_ff    <= 1'h0;
      ramp2_ff  <= 1'h0;
      quick_ff  <= 1'h0;
      freeze_ff <= 1'h0;
      up_ff     <= 1'h0;
      down_ff   <= 1'h0;
      enable_ff <= 1'h0;
      brake_ff  <= 1'h0;
      rdown_ff  <= 1'h0;
      run_ff    <= 1'h0;
      rev_ff    <= 1'h0;
      set_ff    <= 2'h0;
      relay_ff  <= 1'h0;
      dout_ff   <= 1'h0;
      trst_ff   <= 1'h0;
    end else if (clk_en) begin
      tgt_ff    <= nxt_tgt;
      jog_ff    <= nxt_jog;
      ramp2_ff  <= nxt_ramp2;
      quick_ff  <= nxt_quick;
      freeze_ff <= nxt_freeze;
      up_ff     <= nxt_up;
      down_ff   <= nxt_down;
      enable_ff <= nxt_enable;
      brake_ff  <= nxt_brake;
      rdown_ff  <= nxt_rdown;
      run_ff    <= nxt_run;
      rev_ff    <= nxt_rev;
      set_ff    <= nxt_set;
      relay_ff  <= nxt_relay;
      dout_ff   <= nxt_dout;
      trst_ff   <= nxt_trst;
    end
  end

  assign speed_target_sel = tgt_ff;
  assign jog_sel          = jog_ff;
  assign ramp_pair_sel    = ramp2_ff;
  assign ramp_use_quick   = quick_ff;
  assign freeze_freq      = freeze_ff;
  assign freq_speed_up    = up_ff;
  assign freq_speed_down  = down_ff;
  assign outputs_enable   = enable_ff;
  assign dc_brake         = brake_ff;
  assign ramp_down        = rdown_ff;
  assign run_request      = run_ff;
  assign reverse_dir      = rev_ff;
  assign config_set_sel   = set_ff;
  assign relay_out        = relay_ff;
  assign digital_out      = dout_ff;
  assign trip_reset       = trst_ff;
  assign stop_state       = st_ff;

  // ************************************************************
  // status word
  // ************************************************************
  dcsw_status_word u_status (
    .core_clk         (core_clk),
    .reset            (reset),
    .clk_en           (clk_en),
    .drv              (drv),
    .coast_active     (~coast_n),
    .start_active     (start),
    .drive_state_word (drive_state_word)
  );

endmodule

// >>> rtl/dcsw_pkg.sv
package dcsw_pkg;

  // ************************************************************
  // telegram profile
  // ************************************************************
  localparam logic [1:0] DCSW_NATIVE_DRIVE_PROFILE = 2'h1;

  // ************************************************************
  // command word bit positions
  // ************************************************************
  localparam int CMD_TGT_LO    = 0;
  localparam int CMD_TGT_HI    = 1;
  localparam int CMD_DCBRK_N   = 2;
  localparam int CMD_COAST_N   = 3;
  localparam int CMD_QSTOP_N   = 4;
  localparam int CMD_FREEZE_N  = 5;
  localparam int CMD_START     = 6;
  localparam int CMD_RESET     = 7;
  localparam int CMD_JOG       = 8;
  localparam int CMD_RAMP2     = 9;
  localparam int CMD_VALID     = 10;
  localparam int CMD_RELAY     = 11;
  localparam int CMD_DOUT      = 12;
  localparam int CMD_SET_LO    = 13;
  localparam int CMD_SET_HI    = 14;
  localparam int CMD_REVERSE   = 15;

  // ************************************************************
  // status word bit positions
  // ************************************************************
  localparam int STS_CTRL_RDY  = 0;
  localparam int STS_DRV_RDY   = 1;
  localparam int STS_CAN_START = 2;
  localparam int STS_TRIP      = 3;
  localparam int STS_TRIP_LOCK = 6;
  localparam int STS_WARN      = 7;
  localparam int STS_SPD_MATCH = 8;
  localparam int STS_BUS_CTRL  = 9;
  localparam int STS_FREQ_OK   = 10;
  localparam int STS_RUNNING   = 11;
  localparam int STS_VOLT_WARN = 13;
  localparam int STS_CUR_LIM   = 14;
  localparam int STS_THERM     = 15;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] DCSW_CMD_RST = 16'h0000;
  localparam logic [15:0] DCSW_STS_RST = 16'h0000;

  // ************************************************************
  // input combining modes
  // ************************************************************
  typedef enum logic [1:0] {
    DCSW_SRC_DIN,
    DCSW_SRC_BUS,
    DCSW_SRC_OR,
    DCSW_SRC_AND
  } dcsw_src_t;

  typedef struct packed {
    dcsw_src_t coast;
    dcsw_src_t dcbrk;
    dcsw_src_t start;
    dcsw_src_t reverse;
    dcsw_src_t setsel;
    dcsw_src_t target;
  } dcsw_gate_cfg_t;

  typedef struct packed {
    logic       coast_n;
    logic       dcbrk_n;
    logic       start;
    logic       reverse;
    logic [1:0] setsel;
    logic [1:0] target;
    logic       speed_up;
    logic       speed_down;
    logic       reset_coast;
  } dcsw_din_t;

  typedef struct packed {
    logic ready;
    logic tripped;
    logic trip_locked;
    logic warning;
    logic speed_match;
    logic local_ctrl;
    logic freq_in_range;
    logic freq_nonzero;
    logic volt_warn;
    logic cur_limit;
    logic therm_warn;
  } dcsw_drv_sts_t;

  typedef enum logic [2:0] {
    DCSW_ST_IDLE,
    DCSW_ST_RUN,
    DCSW_ST_FROZEN,
    DCSW_ST_RAMP_STOP,
    DCSW_ST_QSTOP,
    DCSW_ST_DCBRAKE,
    DCSW_ST_COAST
  } dcsw_state_t;

  function automatic logic dcsw_gate(input dcsw_src_t m, input logic bus, input logic din);
    unique case (m)
      DCSW_SRC_DIN: dcsw_gate = din;
      DCSW_SRC_BUS: dcsw_gate = bus;
      DCSW_SRC_OR:  dcsw_gate = bus | din;
      DCSW_SRC_AND: dcsw_gate = bus & din;
    endcase
  endfunction

endpackage

// >>> rtl/dcsw_status_word.sv
`timescale 1ns/1ps
module dcsw_status_word
  import dcsw_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          clk_en,
  input  wire dcsw_drv_sts_t drv,
  input  wire logic          coast_active,
  input  wire logic          start_active,
  output logic [15:0]        drive_state_word
);

  logic [15:0] sts_ff;
  logic [15:0] nxt_sts;

  always_comb begin
    nxt_sts                = 16'h0000;                          // RULE_27
    nxt_sts[STS_CTRL_RDY]  = drv.ready;                         // RULE_17
    nxt_sts[STS_DRV_RDY]   = drv.ready & coast_active;          // RULE_17
    nxt_sts[STS_CAN_START] = drv.ready & ~coast_active;         // RULE_18
    nxt_sts[STS_TRIP]      = drv.tripped;                       // RULE_19
    nxt_sts[STS_TRIP_LOCK] = drv.trip_locked;                   // RULE_20
    nxt_sts[STS_WARN]      = drv.warning;                       // RULE_21
    nxt_sts[STS_SPD_MATCH] = drv.speed_match;                   // RULE_22 RULE_23
    nxt_sts[STS_BUS_CTRL]  = ~drv.local_ctrl;                   // RULE_24
    nxt_sts[STS_FREQ_OK]   = drv.freq_in_range;
    nxt_sts[STS_RUNNING]   = start_active | drv.freq_nonzero;   // RULE_25
    nxt_sts[STS_VOLT_WARN] = drv.volt_warn;
    nxt_sts[STS_CUR_LIM]   = drv.cur_limit;                     // RULE_26
    nxt_sts[STS_THERM]     = drv.therm_warn;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sts_ff <= DCSW_STS_RST;
    end else if (clk_en) begin
      sts_ff <= nxt_sts;
    end
  end

  assign drive_state_word = sts_ff;

endmodule

// >>> tb/dcsw_control_status_properties.sv
`timescale 1ns/1ps
module dcsw_control_status_properties
  import dcsw_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          reset,
  input wire logic          clk_en,
  input wire dcsw_drv_sts_t drv,
  input wire logic          trip_reset,
  input wire logic [15:0]   drive_state_word
);
  // ******
  // status word follows the drive one cycle late
  // ******
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence live;
    $past(clk_en) && !$past(reset);
  endsequence
  chk_ready_bit: assert property (live |-> drive_state_word[0] == $past(drv.ready))
    else $error("ready bit wrong");
  chk_trip_bit: assert property (live |-> drive_state_word[3] == $past(drv.tripped))
    else $error("trip bit wrong");
  chk_lock_bit: assert property (live |-> drive_state_word[6] == $past(drv.trip_locked))
    else $error("trip lock bit wrong");
  chk_warn_bit: assert property (live |-> drive_state_word[7] == $past(drv.warning))
    else $error("warning bit wrong");
  chk_speed_match: assert property (live |-> drive_state_word[8] == $past(drv.speed_match))
    else $error("speed match bit wrong");
  chk_bus_ctrl: assert property (live |-> drive_state_word[9] == !$past(drv.local_ctrl))
    else $error("bus control bit wrong");
  chk_cur_limit: assert property (live |-> drive_state_word[14] == $past(drv.cur_limit))
    else $error("current limit bit wrong");
  chk_unused_zero: assert property (drive_state_word[5:4] == 2'h0 && !drive_state_word[12])
    else $error("undefined status bit set");
  chk_reset_pulse: assert property ($rose(trip_reset) |=> !trip_reset)
    else $error("trip reset longer than one cycle");
  cover property ($rose(trip_reset));
  cover property (drive_state_word[3]);
  cover property (drive_state_word[1]);
endmodule

bind dcsw_control_status dcsw_control_status_properties u_dcsw_control_status_properties (
  .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .drv(drv),
  .trip_reset(trip_reset), .drive_state_word(drive_state_word));

// >>> tb/dcsw_control_status_tb.sv
`timescale 1ns/1ps
module dcsw_control_status_tb;
  import dcsw_pkg::*;
  logic core_clk, reset, clk_en, cmd_load, multi_set_mode, relay_bus_assigned, dout_bus_assigned;
  logic jog_sel, ramp_pair_sel, ramp_use_quick, freeze_freq, freq_speed_up, freq_speed_down;
  logic outputs_enable, dc_brake, ramp_down, run_request, reverse_dir, relay_out, digital_out, trip_reset;
  logic [1:0]     telegram_profile, speed_target_sel, config_set_sel;
  logic [15:0]    drive_command_word, drive_state_word;
  dcsw_gate_cfg_t gate_cfg;
  dcsw_din_t      din;
  dcsw_drv_sts_t  drv;
  dcsw_state_t    stop_state;
  int             bad_count = 0;
  int             checked = 0;
  logic           seen;
  dcsw_control_status u_dcsw_control_status (.core_clk, .reset, .clk_en, .telegram_profile, .cmd_load,
    .drive_command_word, .gate_cfg, .din, .multi_set_mode, .relay_bus_assigned, .dout_bus_assigned, .drv,
    .speed_target_sel, .jog_sel, .ramp_pair_sel, .ramp_use_quick, .freeze_freq, .freq_speed_up,
    .freq_speed_down, .outputs_enable, .dc_brake, .ramp_down, .run_request, .reverse_dir, .config_set_sel,
    .relay_out, .digital_out, .trip_reset, .stop_state, .drive_state_word);
  dcsw_master_model u_dcsw_master_model (.core_clk, .telegram_profile, .cmd_load, .drive_command_word);
  // ******
  // helpers
  // ******
  task automatic cmp_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic cmp_vec(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // outputs settle one edge after the word is taken
  task automatic cmd(input logic [15:0] w, input logic [1:0] p = 2'h1);
    u_dcsw_master_model.send(w, p);
    repeat (2) @(negedge core_clk);
  endtask
  task automatic pulse(input logic [15:0] w);
    u_dcsw_master_model.send(w, 2'h1);
    seen = 1'b0;
    repeat (3) begin
      if (trip_reset === 1'b1) seen = 1'b1;
      @(negedge core_clk);
    end
  endtask
  // ******
  // scenarios
  // ******
  task automatic t_run();
    cmd(16'h047c);
    cmp_bit("outputs_enable", 1'b1, outputs_enable);
    cmp_bit("run_request", 1'b1, run_request);
    cmp_bit("dc_brake", 1'b0, dc_brake);
    cmp_bit("sts_can_start", 1'b1, drive_state_word[STS_CAN_START]);
    cmp_bit("sts_drv_rdy", 1'b0, drive_state_word[STS_DRV_RDY]);
    cmp_bit("sts_running", 1'b1, drive_state_word[STS_RUNNING]);
  endtask
  task automatic t_fields();
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      w = 16'h047c | 16'(i) | 16'(i << 13) | 16'(i << 11) | 16'(i << 8) | {i[0], 15'h0000};
      cmd(w);
      cmp_vec("speed_target_sel", 16'(i), {14'h0, speed_target_sel});
      cmp_vec("config_set_sel", 16'(i), {14'h0, config_set_sel});
      cmp_vec("relay_dout", 16'(i), {14'h0, digital_out, relay_out});
      cmp_vec("jog_ramp", 16'(i), {14'h0, ramp_pair_sel, jog_sel});
      cmp_bit("reverse_dir", i[0], reverse_dir);
    end
    cmd(16'h0000);
    cmp_bit("ignored word", 1'b1, outputs_enable);
    cmp_vec("ignored target", 16'h0003, {14'h0, speed_target_sel});
    cmd(16'h0400, 2'h0);
    cmp_bit("other profile", 1'b1, outputs_enable);
    multi_set_mode = 1'b0;
    cmd(16'h047c);
    cmp_vec("set held", 16'h0003, {14'h0, config_set_sel});
    multi_set_mode = 1'b1;
  endtask
  task automatic t_stops();
    cmd(16'h047c);
    cmd(16'h046c);
    cmp_bit("ramp_use_quick", 1'b1, ramp_use_quick);
    cmp_vec("stop_state", 16'(DCSW_ST_QSTOP), 16'(stop_state));
    cmd(16'h047c);
    cmd(16'h043c);
    cmp_bit("ramp_down", 1'b1, ramp_down);
    cmd(16'h047c);
    cmd(16'h0478);
    cmp_bit("dc_brake", 1'b1, dc_brake);
    cmd(16'h047c);
    cmd(16'h0474);
    cmp_bit("coast enable", 1'b0, outputs_enable);
    cmp_bit("sts_drv_rdy", 1'b1, drive_state_word[STS_DRV_RDY]);
    cmp_bit("sts_can_start", 1'b0, drive_state_word[STS_CAN_START]);
    cmd(16'h047c);
    cmd(16'h045c);
    cmp_bit("freeze_freq", 1'b1, freeze_freq);
    cmd(16'h041c);
    cmp_bit("frozen ramp_down", 1'b0, ramp_down);
    cmp_bit("frozen enable", 1'b1, outputs_enable);
    din.speed_up = 1'b1;
    din.speed_down = 1'b1;
    repeat (2) @(negedge core_clk);
    cmp_bit("freq_speed_up", 1'b1, freq_speed_up);
    cmp_bit("freq_speed_down", 1'b1, freq_speed_down);
    din.speed_up = 1'b0;
    din.speed_down = 1'b0;
    cmd(16'h0454);
    cmp_bit("frozen coast", 1'b0, outputs_enable);
  endtask
  task automatic t_reverse();
    gate_cfg.reverse = DCSW_SRC_DIN;
    cmd(16'h847c);
    cmp_bit("reverse input only", 1'b0, reverse_dir);
    din.reverse = 1'b1;
    repeat (3) @(negedge core_clk);
    cmp_bit("reverse from input", 1'b1, reverse_dir);
  endtask
  task automatic t_trip();
    drv.tripped = 1'b1;
    drv.warning = 1'b1;
    drv.cur_limit = 1'b1;
    drv.local_ctrl = 1'b1;
    cmd(16'h047c);
    cmp_vec("status flags", 16'h4089, drive_state_word & 16'h42c9);
    pulse(16'h04fc);
    cmp_bit("reset on rising", 1'b1, seen);
    pulse(16'h04fc);
    cmp_bit("steady one", 1'b0, seen);
    drv.trip_locked = 1'b1;
    cmd(16'h047c);
    cmp_bit("sts_trip_lock", 1'b1, drive_state_word[STS_TRIP_LOCK]);
    pulse(16'h04fc);
    cmp_bit("locked no reset", 1'b0, seen);
  endtask
  // ******
  // main sequence
  // ******
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    close_out();
  end
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    multi_set_mode = 1'b1;
    relay_bus_assigned = 1'b1;
    dout_bus_assigned = 1'b1;
    gate_cfg = '{default: DCSW_SRC_BUS};
    din = '{coast_n: 1'b1, dcbrk_n: 1'b1, default: '0};
    drv = '{ready: 1'b1, default: 1'b0};
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    t_run();
    t_fields();
    t_stops();
    t_reverse();
    t_trip();
    close_out();
  end
endmodule

// >>> tb/dcsw_master_model.sv
`timescale 1ns/1ps
module dcsw_master_model (
  input  wire logic   core_clk,
  output logic [1:0]  telegram_profile,
  output logic        cmd_load,
  output logic [15:0] drive_command_word
);
  initial begin
    telegram_profile = 2'h1;
    cmd_load = 1'b0;
    drive_command_word = 16'h0000;
  end
  // one word per telegram; bus shows junk between telegrams
  task automatic send(input logic [15:0] w, input logic [1:0] prof);
    @(negedge core_clk);
    telegram_profile = prof;
    drive_command_word = w;
    cmd_load = 1'b1;
    @(negedge core_clk);
    cmd_load = 1'b0;
    drive_command_word = ~w;
  endtask
endmodule
